/* hw/mcie_regs.svh */
/*
 * Opcode fields, opcode values, reset values and steps of the core.
 * Assumes it is included by bare name after the package.
 */
`ifndef MCIE_REGS_SVH
`define MCIE_REGS_SVH

// ****************************************
// Instruction fields
// ****************************************
`define MCIE_F_CLS   13:12
`define MCIE_F_SUB   11:8
`define MCIE_F_DST   7
`define MCIE_F_BSEL  9:7
`define MCIE_F_BKIND 11:10
`define MCIE_F_JSEL  11
`define MCIE_F_AHI   15:14
`define MCIE_F_ALO   6:0
`define MCIE_F_KLO   10:0
`define MCIE_F_LIT   7:0
`define MCIE_F_NIB   3:0
`define MCIE_NIB_CY  4
`define MCIE_BYTE_CY 8

// ****************************************
// Opcode classes and sub-operations
// ****************************************
`define MCIE_CLS_BYTE 2'h0
`define MCIE_CLS_LIT  2'h1
`define MCIE_CLS_JMP  2'h2
`define MCIE_CLS_BIT  2'h3
`define MCIE_B_CLR    4'h1
`define MCIE_B_DEC    4'h3
`define MCIE_B_IOR    4'h4
`define MCIE_B_AND    4'h5
`define MCIE_B_ADD    4'h7
`define MCIE_B_MOV    4'h8
`define MCIE_B_COM    4'h9
`define MCIE_B_INC    4'ha
`define MCIE_B_DECSZ  4'hb
`define MCIE_B_INCSZ  4'hf
`define MCIE_L_IOR    4'ha
`define MCIE_L_AND    4'hb
`define MCIE_L_ADD    4'hc
`define MCIE_WDT_WORD 16'h1e04
`define MCIE_J_CALL   1'h0
`define MCIE_K_CLR    2'h0
`define MCIE_K_SET    2'h1
`define MCIE_K_SKLO   2'h2
`define MCIE_K_SKHI   2'h3

// ****************************************
// Reset values and steps
// ****************************************
`define MCIE_PC_RST   13'h0000
`define MCIE_PC_STEP  13'h0001
`define MCIE_PC_SKIP  13'h0002
`define MCIE_BYTE_0   8'h00
`define MCIE_BYTE_1   8'h01
`define MCIE_IR_RST   16'h0000
`define MCIE_FLAG_RST 1'h0
`define MCIE_WDF_RST  1'h1

`endif

/* hw/mcie_pkg.sv */
/*
 * Types of the instruction execution core.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mcie_pkg;
  typedef logic [7:0]  mcie_byte_t;
  typedef logic [8:0]  mcie_addr_t;
  typedef logic [12:0] mcie_pc_t;
  typedef logic [15:0] mcie_word_t;
  // Gray codes along fetch, execute, discarded slot
  typedef enum logic [1:0] {
    MCIE_ST_FETCH  = 2'h0,
    MCIE_ST_EXEC   = 2'h1,
    MCIE_ST_SKIP_A = 2'h3,
    MCIE_ST_SKIP_B = 2'h2
  } mcie_state_t;
endpackage : mcie_pkg

/* hw/mcie_regfile.sv */
/*
 * 512 x 8 register file with one write port and a registered read.
 * Assumes a single clock; read data appear one edge after the address.
 */
`timescale 1ns/100ps
`include "mcie_regs.svh"
module mcie_regfile (
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  input  wire logic               i_we,
  input  wire mcie_pkg::mcie_addr_t i_waddr,
  input  wire mcie_pkg::mcie_byte_t i_wdata,
  input  wire mcie_pkg::mcie_addr_t i_raddr,
  output mcie_pkg::mcie_byte_t      o_rdata
);
  mcie_pkg::mcie_byte_t mem [512];

  // ****************************************
  // Storage
  // ****************************************
  // Contents are not reset, as in a real register RAM
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= `MCIE_BYTE_0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : mcie_regfile

/* hw/mcie_core.sv */
/*
 * Decode and execute core for the arithmetic, logic, bit, skip,
 * call and jump instructions of an 8-bit microcontroller.
 * Assumes program memory shows the word at o_pc while o_fetch is high,
 * and that the return stack and watchdog counter live outside.
 */
// Functional notes
// - Add literal adds k to accumulator, updates carry, nibble carry, zero
// - Add register sums accumulator and register into destination, updates C, DC, Z
// - AND literal ands accumulator with k, only zero flag changes
// - AND register ands into destination, only zero flag changes
// - Bit clear forces selected register bit low, flags untouched
// - Bit set forces selected register bit high, flags untouched
// - Skip if bit low discards next instruction when bit is zero
// - Skip if bit high discards next instruction when bit is one
// - Zero register writes 00h to register and sets zero flag
// - Zero accumulator writes 00h to accumulator and sets zero flag
// - Watchdog kick clears watchdog counter and updates expiry and sleep flags
// - Invert complements register into destination, updates zero flag
// - Decrement lowers register by one into destination, zero flag only
// - Decrement skip zero leaves flags, discards next instruction on zero
// - Increment raises register by one into destination, updates zero flag
// - Increment skip zero leaves flags, discards next instruction on zero
// - OR literal ors accumulator with k, updates zero flag
// - OR register ors into destination, updates zero flag
// - Call pushes PC plus one, loads 13-bit target, two cycles
// - Jump loads 13-bit target, stack untouched, two cycles
// - Copy register moves register to destination, updates zero flag
`timescale 1ns/100ps
`include "mcie_regs.svh"
module mcie_core (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  input  wire mcie_pkg::mcie_word_t i_instr,
  output logic                      o_fetch,
  output mcie_pkg::mcie_pc_t        o_pc,
  output logic                      o_push,
  output mcie_pkg::mcie_pc_t        o_push_addr,
  output logic                      o_wdt_clear,
  output mcie_pkg::mcie_byte_t      o_acc,
  output logic                      o_carry,
  output logic                      o_nibble_carry_flag,
  output logic                      o_zero,
  output logic                      o_watchdog_expiry_flag,
  output logic                      o_sleep_flag
);
  mcie_pkg::mcie_state_t st;
  mcie_pkg::mcie_word_t  ir;
  mcie_pkg::mcie_byte_t  rf_rd;
  mcie_pkg::mcie_byte_t  opnd;
  mcie_pkg::mcie_byte_t  lit;
  mcie_pkg::mcie_byte_t  bmask;
  mcie_pkg::mcie_byte_t  next_res;
  mcie_pkg::mcie_addr_t  raddr;
  mcie_pkg::mcie_addr_t  waddr;
  mcie_pkg::mcie_pc_t    ktgt;
  logic [8:0]            sum;
  logic [4:0]            nsum;
  logic [1:0]            cls;
  logic [3:0]            sub;
  logic                  dst;
  logic                  ex;
  logic                  bit_val;
  logic                  wr_acc;
  logic                  wr_f;
  logic                  upd_z;
  logic                  upd_c;
  logic                  skip;
  logic                  jump;
  logic                  push;
  logic                  wdt;

  // ****************************************
  // Field extraction
  // ****************************************
  assign ex    = (st == mcie_pkg::MCIE_ST_EXEC);
  assign cls   = ir[`MCIE_F_CLS];
  assign sub   = ir[`MCIE_F_SUB];
  assign dst   = ir[`MCIE_F_DST];
  assign lit   = ir[`MCIE_F_LIT];
  assign ktgt  = {ir[`MCIE_F_AHI], ir[`MCIE_F_KLO]};
  // Read address comes from the incoming word so data are ready in execute
  assign raddr = {i_instr[`MCIE_F_AHI], i_instr[`MCIE_F_ALO]};
  assign waddr = {ir[`MCIE_F_AHI], ir[`MCIE_F_ALO]};
  assign o_fetch = (st == mcie_pkg::MCIE_ST_FETCH);

  // One select line per bit of the operand
  generate
    for (genvar g = 0; g < 8; g++) begin : g_bmask
      assign bmask[g] = (ir[`MCIE_F_BSEL] == 3'(g));
    end
  endgenerate
  assign bit_val = |(rf_rd & bmask);

  // ****************************************
  // Adder
  // ****************************************
  assign opnd = (cls == `MCIE_CLS_LIT) ? lit : rf_rd;
  assign sum  = {1'b0, o_acc} + {1'b0, opnd};
  assign nsum = {1'b0, o_acc[`MCIE_F_NIB]} + {1'b0, opnd[`MCIE_F_NIB]};

  mcie_regfile u_rf (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_we    (wr_f),
    .i_waddr (waddr),
    .i_wdata (next_res),
    .i_raddr (raddr),
    .o_rdata (rf_rd)
  );

  // ****************************************
  // Decode and execute
  // ****************************************
  always_comb begin
    next_res = rf_rd;
    wr_acc   = 1'b0;
    wr_f     = 1'b0;
    upd_z    = 1'b0;
    upd_c    = 1'b0;
    skip     = 1'b0;
    jump     = 1'b0;
    push     = 1'b0;
    wdt      = 1'b0;
    if (ex) begin
      case (cls)
        `MCIE_CLS_BYTE: begin
          // Destination bit picks accumulator or register
          wr_acc = !dst;
          wr_f   = dst;
          upd_z  = 1'b1;
          case (sub)
            `MCIE_B_CLR: next_res = `MCIE_BYTE_0;
            `MCIE_B_ADD: begin
              next_res = sum[7:0];
              upd_c    = 1'b1;
            end
            `MCIE_B_AND: next_res = o_acc & rf_rd;
            `MCIE_B_IOR: next_res = o_acc | rf_rd;
            `MCIE_B_COM: next_res = ~rf_rd;
            `MCIE_B_DEC: next_res = rf_rd - `MCIE_BYTE_1;
            `MCIE_B_INC: next_res = rf_rd + `MCIE_BYTE_1;
            `MCIE_B_MOV: next_res = rf_rd;
            `MCIE_B_DECSZ: begin
              next_res = rf_rd - `MCIE_BYTE_1;
              upd_z    = 1'b0;
              skip     = (next_res == `MCIE_BYTE_0);
            end
            `MCIE_B_INCSZ: begin
              next_res = rf_rd + `MCIE_BYTE_1;
              upd_z    = 1'b0;
              skip     = (next_res == `MCIE_BYTE_0);
            end
            default: begin
              // Opcodes outside this core behave as no-operations
              wr_acc = 1'b0;
              wr_f   = 1'b0;
              upd_z  = 1'b0;
            end
          endcase
        end
        `MCIE_CLS_LIT: begin
          wr_acc = 1'b1;
          upd_z  = 1'b1;
          case (sub)
            `MCIE_L_ADD: begin
              next_res = sum[7:0];
              upd_c    = 1'b1;
            end
            `MCIE_L_AND: next_res = o_acc & lit;
            `MCIE_L_IOR: next_res = o_acc | lit;
            default: begin
              wr_acc = 1'b0;
              upd_z  = 1'b0;
              wdt    = (ir == `MCIE_WDT_WORD);
            end
          endcase
        end
        `MCIE_CLS_JMP: begin
          jump = 1'b1;
          push = (ir[`MCIE_F_JSEL] == `MCIE_J_CALL);
        end
        `MCIE_CLS_BIT: begin
          case (ir[`MCIE_F_BKIND])
            `MCIE_K_CLR: begin
              next_res = rf_rd & ~bmask;
              wr_f     = 1'b1;
            end
            `MCIE_K_SET: begin
              next_res = rf_rd | bmask;
              wr_f     = 1'b1;
            end
            `MCIE_K_SKLO: skip = !bit_val;
            default:      skip = bit_val;
          endcase
        end
        default: begin
          skip = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Sequencer and program counter
  // ****************************************
  // Skips and branches spend a second instruction slot doing nothing
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st <= mcie_pkg::MCIE_ST_FETCH;
    end else begin
      case (st)
        mcie_pkg::MCIE_ST_FETCH:  st <= mcie_pkg::MCIE_ST_EXEC;
        mcie_pkg::MCIE_ST_EXEC: begin
          if (skip || jump) begin
            st <= mcie_pkg::MCIE_ST_SKIP_A;
          end else begin
            st <= mcie_pkg::MCIE_ST_FETCH;
          end
        end
        mcie_pkg::MCIE_ST_SKIP_A: st <= mcie_pkg::MCIE_ST_SKIP_B;
        mcie_pkg::MCIE_ST_SKIP_B: st <= mcie_pkg::MCIE_ST_FETCH;
        default:                  st <= mcie_pkg::MCIE_ST_FETCH;
      endcase
    end
  end

  // The skipped word is never fetched: the counter steps over it at once
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pc <= `MCIE_PC_RST;
    end else if (ex) begin
      if (jump) begin
        o_pc <= ktgt;
      end else if (skip) begin
        o_pc <= o_pc + `MCIE_PC_SKIP;
      end else begin
        o_pc <= o_pc + `MCIE_PC_STEP;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ir <= `MCIE_IR_RST;
    end else if (o_fetch) begin
      ir <= i_instr;
    end
  end

  // ****************************************
  // Accumulator and flags
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_acc <= `MCIE_BYTE_0;
    end else if (wr_acc) begin
      o_acc <= next_res;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_zero <= `MCIE_FLAG_RST;
    end else if (upd_z) begin
      o_zero <= (next_res == `MCIE_BYTE_0);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_carry             <= `MCIE_FLAG_RST;
      o_nibble_carry_flag <= `MCIE_FLAG_RST;
    end else if (upd_c) begin
      o_carry             <= sum[`MCIE_BYTE_CY];
      o_nibble_carry_flag <= nsum[`MCIE_NIB_CY];
    end
  end

  // ****************************************
  // Stack push and watchdog side effects
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_push      <= 1'b0;
      o_push_addr <= `MCIE_PC_RST;
      o_wdt_clear <= 1'b0;
    end else begin
      o_push      <= push;
      o_wdt_clear <= wdt;
      if (push) begin
        o_push_addr <= o_pc + `MCIE_PC_STEP;
      end
    end
  end

  // Both status bits read as one after a kick, the usual awake state
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_watchdog_expiry_flag <= `MCIE_WDF_RST;
      o_sleep_flag           <= `MCIE_WDF_RST;
    end else if (wdt) begin
      o_watchdog_expiry_flag <= 1'b1;
      o_sleep_flag           <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  logic op_addl;
  logic op_andl;
  logic op_zero_accumulator_op;
  logic op_cnt_sz;
  assign op_addl   = ex && (cls == `MCIE_CLS_LIT) && (sub == `MCIE_L_ADD);
  assign op_andl   = ex && (cls == `MCIE_CLS_LIT) && (sub == `MCIE_L_AND);
  assign op_zero_accumulator_op   = ex && (cls == `MCIE_CLS_BYTE) && (sub == `MCIE_B_CLR) && !dst;
  assign op_cnt_sz = ex && (cls == `MCIE_CLS_BYTE) && ((sub == `MCIE_B_DECSZ) || (sub == `MCIE_B_INCSZ));

  sequence s_nop_slot;
    st == mcie_pkg::MCIE_ST_SKIP_A ##1 st == mcie_pkg::MCIE_ST_SKIP_B ##1 o_fetch;
  endsequence

  property p_add_lit;
    op_addl |=> (o_acc == 8'($past(o_acc) + $past(lit))) && (o_zero == (o_acc == `MCIE_BYTE_0));
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("literal add result wrong");

  property p_add_carry;
    op_addl |=> o_carry == ((9'($past(lit)) + 9'($past(o_acc))) > 9'h0ff);
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("carry out of bit 7 wrong");

  property p_and_lit;
    op_andl |=> (o_acc == ($past(o_acc) & $past(lit))) && $stable(o_carry);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("literal and wrong or carry moved");

  property p_clr_acc;
    op_zero_accumulator_op |=> (o_acc == `MCIE_BYTE_0) && o_zero;
  endproperty
  a_clr_acc: assert property (p_clr_acc) else $error("accumulator clear failed");

  property p_skip_slot;
    (ex && skip) |=> s_nop_slot ##0 (o_pc == $past(o_pc, 3) + `MCIE_PC_SKIP);
  endproperty
  a_skip_slot: assert property (p_skip_slot) else $error("skip did not discard one slot");

  property p_cnt_flags;
    op_cnt_sz |=> $stable(o_zero) && $stable(o_carry) && $stable(o_nibble_carry_flag);
  endproperty
  a_cnt_flags: assert property (p_cnt_flags) else $error("counting skip changed a flag");

  property p_call;
    (ex && push) |=> o_push && (o_push_addr == $past(o_pc) + `MCIE_PC_STEP) ##0 s_nop_slot;
  endproperty
  a_call: assert property (p_call) else $error("call push or timing wrong");

  property p_jump;
    (ex && jump && !push) |=> !o_push && (o_pc == $past(ktgt)) ##0 s_nop_slot;
  endproperty
  a_jump: assert property (p_jump) else $error("jump target or timing wrong");

  property p_wdt;
    (ex && wdt) |=> o_wdt_clear && o_watchdog_expiry_flag && o_sleep_flag ##1 !o_wdt_clear;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog kick not signalled");
endmodule : mcie_core

/* verif/mcie_prog_mem.sv */
/*
 * Program memory model that feeds instruction words to the core.
 * Assumes the bench loads it before reset is released.
 */
`timescale 1ns/100ps
module mcie_prog_mem (
  input  wire logic                 i_clk,
  input  wire logic                 i_fetch,
  input  wire mcie_pkg::mcie_pc_t   i_pc,
  input  wire logic                 i_load,
  input  wire mcie_pkg::mcie_pc_t   i_load_addr,
  input  wire mcie_pkg::mcie_word_t i_load_data,
  output mcie_pkg::mcie_word_t      o_instr
);
  // ****************************************
  // Storage
  // ****************************************
  mcie_pkg::mcie_word_t mem [0:8191];
  mcie_pkg::mcie_word_t last;

  // Loaded on the strobe edge, so a whole program fits inside reset
  always @(posedge i_load) begin
    mem[i_load_addr] = i_load_data;
  end

  always_ff @(posedge i_clk) begin
    if (i_fetch) begin
      last <= mem[i_pc];
    end
  end

  // Outside fetch the bus shows the inverse of the last word, so a late sample is caught
  assign o_instr = i_fetch ? mem[i_pc] : ~last;
endmodule : mcie_prog_mem

/* verif/mcie_core_test.sv */
/*
 * Self-checking bench for the core: runs a program row by row.
 * Assumes the program memory model and the design files.
 */
`timescale 1ns/100ps
module mcie_core_test;
  // ****************************************
  // Signals
  // ****************************************
  typedef struct packed {
    mcie_pkg::mcie_pc_t   pc;
    mcie_pkg::mcie_word_t word;
    mcie_pkg::mcie_byte_t acc;
    logic [2:0]           flags;
    mcie_pkg::mcie_pc_t   next_pc;
  } mcie_row_t;
  localparam int NUM_ROWS = 41;
  // Flags are carry, nibble carry, zero
  mcie_row_t rows [NUM_ROWS] = '{
    '{13'h0000, 16'h0140, 8'h00, 3'h1, 13'h0001}, '{13'h0001, 16'h1a10, 8'h10, 3'h0, 13'h0002},
    '{13'h0002, 16'h1c15, 8'h25, 3'h0, 13'h0003}, '{13'h0003, 16'h1cdb, 8'h00, 3'h7, 13'h0004},
    '{13'h0004, 16'h1a17, 8'h17, 3'h6, 13'h0005}, '{13'h0005, 16'hc1c2, 8'h17, 3'h7, 13'h0006},
    '{13'h0006, 16'hcac2, 8'h17, 3'h6, 13'h0007}, '{13'h0007, 16'hc742, 8'h18, 3'h0, 13'h0008},
    '{13'h0008, 16'hc3c2, 8'h18, 3'h1, 13'h0009}, '{13'h0009, 16'hc342, 8'hff, 3'h0, 13'h000a},
    '{13'h000a, 16'hc9c2, 8'hff, 3'h0, 13'h000b}, '{13'h000b, 16'h1b5f, 8'h5f, 3'h0, 13'h000c},
    '{13'h000c, 16'hc5c2, 8'h5f, 3'h0, 13'h000d}, '{13'h000d, 16'h0140, 8'h00, 3'h1, 13'h000e},
    '{13'h000e, 16'hc442, 8'h5f, 3'h0, 13'h000f}, '{13'h000f, 16'hf342, 8'h5f, 3'h0, 13'h0010},
    '{13'h0010, 16'hf7c2, 8'h5f, 3'h0, 13'h0011}, '{13'h0011, 16'hc842, 8'h9f, 3'h0, 13'h0012},
    '{13'h0012, 16'hfac2, 8'h9f, 3'h0, 13'h0014}, '{13'h0014, 16'hfec2, 8'h9f, 3'h0, 13'h0015},
    '{13'h0015, 16'hfe42, 8'h9f, 3'h0, 13'h0017}, '{13'h0017, 16'hfa42, 8'h9f, 3'h0, 13'h0018},
    '{13'h0018, 16'h0140, 8'h00, 3'h1, 13'h0019}, '{13'h0019, 16'hcf42, 8'ha0, 3'h1, 13'h001a},
    '{13'h001a, 16'hc1c2, 8'ha0, 3'h1, 13'h001b}, '{13'h001b, 16'hcbc2, 8'ha0, 3'h1, 13'h001c},
    '{13'h001c, 16'hcfc2, 8'ha0, 3'h1, 13'h001e}, '{13'h001e, 16'hcac2, 8'ha0, 3'h0, 13'h001f},
    '{13'h001f, 16'hcbc2, 8'ha0, 3'h0, 13'h0021}, '{13'h0021, 16'h1e04, 8'ha0, 3'h0, 13'h0022},
    '{13'h0022, 16'h2900, 8'ha0, 3'h0, 13'h0100}, '{13'h0100, 16'ha234, 8'ha0, 3'h0, 13'h1234},
    '{13'h1234, 16'h1dff, 8'ha0, 3'h0, 13'h1235}, '{13'h1235, 16'hc8c2, 8'ha0, 3'h1, 13'h1236},
    '{13'h1236, 16'hc7c2, 8'ha0, 3'h0, 13'h1237}, '{13'h1237, 16'hc742, 8'h40, 3'h4, 13'h1238},
    // Last rows vary the top address pair so an address that drops it is caught
    '{13'h1238, 16'h01c2, 8'h40, 3'h5, 13'h1239}, '{13'h1239, 16'h0ac2, 8'h40, 3'h4, 13'h123a},
    '{13'h123a, 16'hc842, 8'ha0, 3'h4, 13'h123b}, '{13'h123b, 16'h41c2, 8'ha0, 3'h5, 13'h123c},
    '{13'h123c, 16'h0842, 8'h01, 3'h4, 13'h123d}};
  logic                 i_clk;
  logic                 i_reset;
  logic                 load;
  mcie_pkg::mcie_pc_t   load_addr;
  mcie_pkg::mcie_word_t load_data;
  mcie_pkg::mcie_word_t instr;
  logic                 fetch;
  mcie_pkg::mcie_pc_t   pc;
  logic                 push;
  mcie_pkg::mcie_pc_t   push_addr;
  logic                 wdt_clear;
  mcie_pkg::mcie_byte_t acc;
  logic                 carry;
  logic                 nibble_carry_flag;
  logic                 zero;
  logic                 watchdog_expiry_flag;
  logic                 sleep_flag;
  int                   num_errors;
  int                   num_checks;

  mcie_core u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_instr(instr), .o_fetch(fetch), .o_pc(pc),
    .o_push(push), .o_push_addr(push_addr), .o_wdt_clear(wdt_clear), .o_acc(acc), .o_carry(carry),
    .o_nibble_carry_flag(nibble_carry_flag), .o_zero(zero), .o_watchdog_expiry_flag(watchdog_expiry_flag),
    .o_sleep_flag(sleep_flag));
  mcie_prog_mem u_mem (.i_clk(i_clk), .i_fetch(fetch), .i_pc(pc), .i_load(load), .i_load_addr(load_addr),
    .i_load_data(load_data), .o_instr(instr));

  always #25 i_clk = ~i_clk;

  // ****************************************
  // Compare tasks and closing
  // ****************************************
  task automatic check_byte(input string what, input mcie_pkg::mcie_byte_t exp, input mcie_pkg::mcie_byte_t got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_byte
  task automatic check_pc(input string what, input mcie_pkg::mcie_pc_t exp, input mcie_pkg::mcie_pc_t got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_pc
  task automatic check_bits(input string what, input logic [2:0] exp, input logic [2:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bits
  task automatic test_done;
    $display("Checks made %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic load_word(input mcie_pkg::mcie_pc_t a, input mcie_pkg::mcie_word_t w);
    load_addr = a;
    load_data = w;
    #1 load = 1'b1;
    #1 load = 1'b0;
  endtask : load_word

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int cycles;
    logic pushed;
    logic kicked;
    i_clk = 1'b0;
    i_reset = 1'b1;
    load = 1'b0;
    load_addr = 13'h0000;
    load_data = 16'h0000;
    num_errors = 0;
    num_checks = 0;
    foreach (rows[i]) load_word(rows[i].pc, rows[i].word);
    // Skipped slots hold a word that would clear the accumulator if it ran
    foreach (rows[i]) if (rows[i].next_pc == rows[i].pc + 13'h0002) load_word(rows[i].pc + 13'h0001, 16'h0140);
    repeat (20) @(posedge i_clk);
    #1 i_reset = 1'b0;
    check_bits("reset flags", 3'h0, {carry, nibble_carry_flag, zero});
    check_bits("reset wdt flags", 3'h7, {watchdog_expiry_flag, sleep_flag, fetch & ~push & ~wdt_clear});
    check_byte("reset acc", 8'h00, acc);
    foreach (rows[i]) begin
      check_pc("fetch pc", rows[i].pc, pc);
      cycles = 0;
      pushed = 1'b0;
      kicked = 1'b0;
      do begin
        @(posedge i_clk);
        #1 cycles++;
        if (push === 1'b1) pushed = 1'b1;
        if (wdt_clear === 1'b1) kicked = 1'b1;
      end while (fetch !== 1'b1 && cycles < 8);
      if (fetch !== 1'b1) begin
        num_errors++;
        test_done();
      end
      check_byte("acc", rows[i].acc, acc);
      check_bits("flags", rows[i].flags, {carry, nibble_carry_flag, zero});
      check_pc("next pc", rows[i].next_pc, pc);
      check_pc("cycles", (rows[i].next_pc == rows[i].pc + 13'h0001) ? 13'h0002 : 13'h0004, 13'(cycles));
      check_bits("pulses", {1'b0, rows[i].word[13:11] == 3'h4, rows[i].word == 16'h1e04}, {1'b0, pushed, kicked});
      if (pushed) check_pc("push addr", rows[i].pc + 13'h0001, push_addr);
      check_bits("wdt flags", 3'h3, {1'b0, watchdog_expiry_flag, sleep_flag});
    end
    // Reset again in mid-run, before the next fetch edge
    i_reset = 1'b1;
    repeat (2) @(posedge i_clk);
    #1 i_reset = 1'b0;
    check_pc("pc after reset", 13'h0000, pc);
    check_byte("acc after reset", 8'h00, acc);
    check_bits("flags after reset", 3'h0, {carry, nibble_carry_flag, zero});
    check_bits("wdt flags after reset", 3'h7, {watchdog_expiry_flag, sleep_flag, fetch & ~push & ~wdt_clear});
    test_done();
  end
endmodule : mcie_core_test
